// [dcr_map.svh]
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
// host datagram address fields
`define DCR_SPACE_RAM      1'b1
`define DCR_RANGE_CFG      1'b0
`define DCR_RANGE_WAVE     1'b1
// register space offsets
`define DCR_REG_CTRL       6'h00
`define DCR_REG_STAT       6'h01
`define DCR_CTRL_START_BIT 2
`define DCR_LAST_RST       2'h0
`define DCR_DRV_RST        2'h0
// code word layout
`define DCR_FLAG_BIT       5
`define DCR_SUB_POL        3'h6
`define DCR_SUB_FD         3'h7
`define DCR_CODE_CONST0    5'h10
`define DCR_CODE_CONST1    5'h11
`define DCR_CODE_DIR       5'h12
`define DCR_CODE_STEP      5'h13
`define DCR_CODE_RSVD      5'h14
// wave expansion
`define DCR_QUARTER        8'h40
`define DCR_SNAP_LAST      3'h5
`endif

// [dcr_pkg.sv]
package dcr_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SNAP,
    ST_LOAD,
    ST_SHIFT
  } dcr_state_type;
  typedef logic [5:0] dcr_word_type;
  typedef logic [4:0] dcr_code_type;
  typedef logic [7:0] dcr_pos_type;
endpackage

// [dcr_ram_if.sv]
`timescale 1ns/1ps
interface dcr_ram_if;
  import dcr_pkg::*;
  logic         wr_en;
  logic [5:0]   wr_addr;
  logic [11:0]  wr_data;
  logic [5:0]   host_addr;
  logic [11:0]  host_data;
  logic [6:0]   seq_addr;
  dcr_word_type seq_word;
  logic [6:0]   wave_addr;
  dcr_word_type wave_word;
  modport store (input wr_en, wr_addr, wr_data, host_addr, seq_addr, wave_addr,
                 output host_data, seq_word, wave_word);
  modport ctrl (output wr_en, wr_addr, wr_data, host_addr, seq_addr,
                input host_data, seq_word);
  modport wave (output wave_addr, input wave_word);
endinterface

// [dcr_ram.sv]
`timescale 1ns/1ps
module dcr_ram (
  // clock
  input wire logic  clock_in,
  // access ports
  dcr_ram_if.store  bus
);
  import dcr_pkg::*;

  // no reset: contents are random after power-up
  dcr_word_type mem [0:127];

  always_ff @(posedge clock_in) begin
    if (bus.wr_en) begin
      mem[{bus.wr_addr, 1'b0}] <= bus.wr_data[5:0];
      mem[{bus.wr_addr, 1'b1}] <= bus.wr_data[11:6];
    end
  end

  // three read ports: host, sequencer, wave lookup
  assign bus.host_data = {mem[{bus.host_addr, 1'b1}], mem[{bus.host_addr, 1'b0}]};
  assign bus.seq_word  = mem[bus.seq_addr];
  assign bus.wave_word = mem[bus.wave_addr];
endmodule

// [dcr_wave.sv]
`timescale 1ns/1ps
`include "dcr_map.svh"
module dcr_wave (
  // microstep position, 256 steps per period
  input wire dcr_pkg::dcr_pos_type  pos_in,
  // expanded sample
  output logic [5:0]                amp_out,
  output logic                      neg_out,
  // table lookup
  dcr_ram_if.wave                   tbl
);
  import dcr_pkg::*;

  wire [5:0] idx;

  // odd quadrants run the quarter table backwards
  assign idx           = pos_in[6] ? ~pos_in[5:0] : pos_in[5:0];
  assign tbl.wave_addr = {`DCR_RANGE_WAVE, idx};
  assign amp_out       = tbl.wave_word;
  // second half period flips the polarity
  assign neg_out       = pos_in[7];
endmodule

// [dcr_top.sv]
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "dcr_map.svh"
// Summary of operation
// - 128 six-bit cells, 64 double-word addresses
// - datagram bit 31 picks registers or RAM
// - address bit 30 splits config and wave
// - config word holds flag and 5-bit code
// - code words fetched in order during send
// - flag advances driver; last index ends frame
// - quarter wave expands to full, plus 90 degrees
// - one wave table shared by all motors
// - signals kept separately per driver position
// - each coil: dac, polarity, fast decay
// - each signal has its own code
// - coil a codes 00..07
// - coil b codes 08..0F
// - 10 sends zero, 11 sends one
// - 12 sends direction of addressed motor
// - 13 sends step bit
// - codes 14..1F send one
// - snapshot signals before frame starts
// - first word is even cell, driver zero
module dcr_top (
  // clock and reset
  input  wire logic                      clock_in,
  input  wire logic                      resetn_in,
  // host datagram port
  input  wire logic [6:0]                host_addr_in,
  input  wire logic [23:0]               host_wdata_in,
  input  wire logic                      host_wr_in,
  input  wire logic                      host_rd_in,
  output logic [23:0]                    host_rdata_out,
  // microstep unit
  input  wire logic                      start_in,
  input  wire dcr_pkg::dcr_pos_type [2:0] mstep_pos_in,
  input  wire logic [2:0]                dir_in,
  input  wire logic [2:0]                step_in,
  input  wire logic [2:0]                coil_a_fast_decay_in,
  input  wire logic [2:0]                coil_b_fast_decay_in,
  // driver chain
  input  wire logic                      link_clk_in,
  output logic                           chain_sel_n_out,
  output logic                           chain_data_out,
  output logic [1:0]                     driver_pos_out,
  output logic                           busy_out
);
  import dcr_pkg::*;

  dcr_ram_if ram_bus ();

  //////////////////////////////////////////////////////////////////////
  // state

  dcr_state_type    state_r;
  dcr_state_type    state_nxt;
  logic [5:0]       word_idx_r;
  logic [1:0]       drv_r;
  logic [2:0]       snap_cnt_r;
  logic [1:0]       last_driver_index_r;
  logic             data_r;
  logic [5:0][5:0]  dac_r;
  logic [5:0]       pol_r;
  logic [2:0]       fda_r;
  logic [2:0]       fdb_r;
  logic [2:0]       dir_r;
  logic [2:0]       step_r;
  logic             lk_s1_r;
  logic             lk_s2_r;
  logic             lk_s3_r;
  logic [23:0]      rdata_r;

  //////////////////////////////////////////////////////////////////////
  // decode

  wire              space_ram;
  wire              ctrl_wr;
  wire              req;
  wire              link_rise;
  wire              next_driver_flag;
  dcr_code_type     code;
  wire              at_last;
  wire              done;
  wire [1:0]        snap_motor;
  dcr_pos_type      wave_pos;
  wire [5:0]        wave_amp;
  wire              wave_neg;
  wire              sel_bit;
  logic [23:0]      rd_mux;

  assign space_ram        = host_addr_in[6] == `DCR_SPACE_RAM;
  assign ctrl_wr          = host_wr_in & ~space_ram & (host_addr_in[5:0] == `DCR_REG_CTRL);
  assign req              = start_in | (ctrl_wr & host_wdata_in[`DCR_CTRL_START_BIT]);
  assign link_rise        = lk_s2_r & ~lk_s3_r;
  assign next_driver_flag = ram_bus.seq_word[`DCR_FLAG_BIT];
  assign code             = ram_bus.seq_word[4:0];
  assign at_last          = drv_r == last_driver_index_r;
  assign done             = (state_r == ST_SHIFT) & link_rise & next_driver_flag & at_last;
  assign snap_motor       = snap_cnt_r[2:1];
  // coil b runs a quarter period ahead of coil a
  assign wave_pos         = mstep_pos_in[snap_motor] + (snap_cnt_r[0] ? `DCR_QUARTER : 8'h00);

  //////////////////////////////////////////////////////////////////////
  // RAM and wave table

  assign ram_bus.wr_en     = host_wr_in & space_ram;
  assign ram_bus.wr_addr   = host_addr_in[5:0];
  assign ram_bus.wr_data   = host_wdata_in[11:0];
  assign ram_bus.host_addr = host_addr_in[5:0];
  assign ram_bus.seq_addr  = {`DCR_RANGE_CFG, word_idx_r};

  dcr_ram u_ram (
    .clock_in (clock_in),
    .bus      (ram_bus.store)
  );

  // one lookup serves every motor in turn
  dcr_wave u_wave (
    .pos_in  (wave_pos),
    .amp_out (wave_amp),
    .neg_out (wave_neg),
    .tbl     (ram_bus.wave)
  );

  //////////////////////////////////////////////////////////////////////
  // primary signal selection

  // snapshot passed in, so the assign re-evaluates when it changes
  function automatic logic pick_bit(
    input dcr_code_type    c,
    input logic [1:0]      d,
    input logic [5:0][5:0] dac,
    input logic [5:0]      pol,
    input logic [2:0]      fa,
    input logic [2:0]      fb,
    input logic [2:0]      dr,
    input logic [2:0]      st
  );
    logic [2:0] slot;
    slot = {d, c[3]};
    if (!c[4]) begin
      case (c[2:0])
        `DCR_SUB_POL: pick_bit = pol[slot];
        `DCR_SUB_FD:  pick_bit = c[3] ? fb[d] : fa[d];
        default:      pick_bit = dac[slot][c[2:0]];
      endcase
    end else begin
      case (c)
        `DCR_CODE_CONST0: pick_bit = 1'b0;
        `DCR_CODE_CONST1: pick_bit = 1'b1;
        `DCR_CODE_DIR:    pick_bit = dr[d];
        `DCR_CODE_STEP:   pick_bit = st[d];
        default:          pick_bit = 1'b1;
      endcase
    end
  endfunction

  assign sel_bit = pick_bit(code, drv_r, dac_r, pol_r, fda_r, fdb_r, dir_r, step_r);

  //////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (req) state_nxt = ST_SNAP;
      end
      ST_SNAP: begin
        if (snap_cnt_r == `DCR_SNAP_LAST) state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        state_nxt = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (link_rise) state_nxt = done ? ST_IDLE : ST_LOAD;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // link clock is asynchronous: two stages, third only for the edge
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lk_s1_r <= 1'b0;
      lk_s2_r <= 1'b0;
      lk_s3_r <= 1'b0;
    end else begin
      lk_s1_r <= link_clk_in;
      lk_s2_r <= lk_s1_r;
      lk_s3_r <= lk_s2_r;
    end
  end

  // without a stored flag the index wraps and the frame never ends
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      word_idx_r <= 6'h00;
      drv_r      <= `DCR_DRV_RST;
    end else if (state_r == ST_IDLE) begin
      word_idx_r <= 6'h00;
      drv_r      <= `DCR_DRV_RST;
    end else if (done) begin
      word_idx_r <= 6'h00;
      drv_r      <= `DCR_DRV_RST;
    end else if (state_r == ST_SHIFT && link_rise) begin
      word_idx_r <= word_idx_r + 6'h01;
      if (next_driver_flag) drv_r <= drv_r + 2'h1;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_r <= 1'b0;
    end else if (state_r == ST_LOAD) begin
      data_r <= sel_bit;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // snapshot

  // levels are taken at the request; wave samples follow over six cycles,
  // trading a short skew for a single table port
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fda_r  <= 3'h0;
      fdb_r  <= 3'h0;
      dir_r  <= 3'h0;
      step_r <= 3'h0;
    end else if (state_r == ST_IDLE && req) begin
      fda_r  <= coil_a_fast_decay_in;
      fdb_r  <= coil_b_fast_decay_in;
      dir_r  <= dir_in;
      step_r <= step_in;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      snap_cnt_r <= 3'h0;
      dac_r      <= '0;
      pol_r      <= 6'h00;
    end else if (state_r == ST_SNAP) begin
      snap_cnt_r         <= snap_cnt_r + 3'h1;
      dac_r[snap_cnt_r]  <= wave_amp;
      pol_r[snap_cnt_r]  <= wave_neg;
    end else begin
      snap_cnt_r <= 3'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // host registers

  always_comb begin
    rd_mux = 24'h000000;
    if (space_ram) begin
      rd_mux = {12'h000, ram_bus.host_data};
    end else if (host_addr_in[5:0] == `DCR_REG_CTRL) begin
      rd_mux = {22'h0, last_driver_index_r};
    end else if (host_addr_in[5:0] == `DCR_REG_STAT) begin
      rd_mux = {21'h0, busy_out, drv_r};
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_driver_index_r <= `DCR_LAST_RST;
    end else if (ctrl_wr) begin
      last_driver_index_r <= host_wdata_in[1:0];
    end
  end

  // read data stand only in the cycle after each cycle of the read strobe, else zero
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_r <= 24'h000000;
    end else begin
      rdata_r <= host_rd_in ? rd_mux : 24'h000000;
    end
  end

  assign host_rdata_out  = rdata_r;
  assign busy_out        = state_r != ST_IDLE;
  assign chain_sel_n_out = ~((state_r == ST_LOAD) | (state_r == ST_SHIFT));
  assign chain_data_out  = data_r;
  assign driver_pos_out  = drv_r;

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  sequence s_snap;
    (state_r == ST_SNAP) [*6];
  endsequence

  sequence s_first;
    (state_r == ST_LOAD) && (word_idx_r == 6'h00) && (drv_r == 2'h0);
  endsequence

  property p_snap;
    (state_r == ST_IDLE) && req |=> s_snap ##1 s_first;
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot or first word wrong");

  property p_end;
    done |=> (state_r == ST_IDLE) && (drv_r == 2'h0) && chain_sel_n_out;
  endproperty
  a_end: assert property (p_end) else $error("frame did not end at last driver");

  property p_inc;
    (state_r == ST_SHIFT) && link_rise && next_driver_flag && !at_last
      |=> (drv_r == $past(drv_r) + 2'h1) && (state_r == ST_LOAD);
  endproperty
  a_inc: assert property (p_inc) else $error("driver counter did not advance");

  property p_next_word;
    (state_r == ST_SHIFT) && link_rise && !done |=> word_idx_r == $past(word_idx_r) + 6'h01;
  endproperty
  a_next_word: assert property (p_next_word) else $error("code word not fetched in order");

  property p_zero;
    (state_r == ST_LOAD) && (code == `DCR_CODE_CONST0) |=> !chain_data_out;
  endproperty
  a_zero: assert property (p_zero) else $error("zero code sent a one");

  property p_rsvd;
    (state_r == ST_LOAD) && (code >= `DCR_CODE_RSVD) |=> chain_data_out;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code sent a zero");

  property p_dir;
    (state_r == ST_LOAD) && (code == `DCR_CODE_DIR) |=> chain_data_out == dir_r[drv_r];
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");

  property p_step;
    (state_r == ST_LOAD) && (code == `DCR_CODE_STEP) |=> chain_data_out == step_r[drv_r];
  endproperty
  a_step: assert property (p_step) else $error("step bit wrong");

  property p_dac;
    (state_r == ST_LOAD) && !code[4] && (code[2:0] < `DCR_SUB_POL)
      |=> chain_data_out == dac_r[{drv_r, $past(code[3])}][$past(code[2:0])];
  endproperty
  a_dac: assert property (p_dac) else $error("dac bit wrong");

  property p_ram_rd;
    host_rd_in && space_ram |=> host_rdata_out[23:12] == 12'h000;
  endproperty
  a_ram_rd: assert property (p_ram_rd) else $error("unused RAM data bits not zero");
endmodule

// [dcr_chain_model.sv]
`timescale 1ns/1ps
module dcr_chain_model (
  // driver chain side
  input  wire logic       sel_n_in,
  input  wire logic       data_in,
  input  wire logic [1:0] pos_in,
  output logic            link_clk_out
);
  logic       bits_q[$];
  logic [1:0] pos_q[$];
  ////////////////////////////////////////////////////////////////
  // link clock runs only inside frames, off the system clock phase
  initial begin
    link_clk_out = 1'b0;
    forever begin
      wait (sel_n_in === 1'b0);
      #37;
      while (sel_n_in === 1'b0) begin
        #400;
        if (sel_n_in === 1'b0) begin
          link_clk_out = 1'b1;
          bits_q.push_back(data_in);
          pos_q.push_back(pos_in);
          #400;
          link_clk_out = 1'b0;
        end
      end
    end
  end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import dcr_pkg::*;
  logic              clock_in, resetn_in, host_wr, host_rd, start, link_clk, sel_n, data, busy;
  logic [6:0]        host_addr;
  logic [23:0]       host_wdata, host_rdata;
  dcr_pos_type [2:0] mpos, e_pos;
  logic [2:0]        dir_v, step_v, fda_v, fdb_v, e_dir, e_step, e_fda, e_fdb;
  logic [1:0]        drv_pos;
  logic [5:0]        cfg[36];
  int                error_cnt, num_checks;
  ////////////////////////////////////////////////////////////////
  always #50 clock_in = ~clock_in;
  dcr_top dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .host_addr_in(host_addr),
    .host_wdata_in(host_wdata), .host_wr_in(host_wr), .host_rd_in(host_rd), .host_rdata_out(host_rdata),
    .start_in(start), .mstep_pos_in(mpos), .dir_in(dir_v), .step_in(step_v),
    .coil_a_fast_decay_in(fda_v), .coil_b_fast_decay_in(fdb_v), .link_clk_in(link_clk),
    .chain_sel_n_out(sel_n), .chain_data_out(data), .driver_pos_out(drv_pos), .busy_out(busy));
  dcr_chain_model chain_u (.sel_n_in(sel_n), .data_in(data), .pos_in(drv_pos), .link_clk_out(link_clk));
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic host_write(input logic [6:0] a, input logic [23:0] d);
    @(posedge clock_in);
    host_addr  <= a;
    host_wdata <= d;
    host_wr    <= 1'b1;
    @(posedge clock_in);
    host_wr    <= 1'b0;
  endtask
  task automatic host_check(input logic [6:0] a, input logic [23:0] e, input string nm);
    @(posedge clock_in);
    host_addr <= a;
    host_rd   <= 1'b1;
    @(posedge clock_in);
    host_rd   <= 1'b0;
    #10;
    chk(nm, e, host_rdata);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge clock_in);
      n++;
    end
    if (busy !== 1'b0) begin
      error_cnt++;
      summarize();
    end
  endtask
  // expected serial bit from the inputs seen at the request
  function automatic logic exp_bit(input logic [4:0] c, input int d);
    logic [7:0] p;
    logic [5:0] amp;
    p   = e_pos[d] + (c[3] ? 8'h40 : 8'h00);
    amp = (p[6] ? 6'h3F - p[5:0] : p[5:0]) ^ 6'h2A;
    if (c[4]) exp_bit = (c == 5'h10) ? 1'b0 : (c == 5'h12) ? e_dir[d] : (c == 5'h13) ? e_step[d] : 1'b1;
    else if (c[2:0] == 3'h7) exp_bit = c[3] ? e_fdb[d] : e_fda[d];
    else if (c[2:0] == 3'h6) exp_bit = p[7];
    else exp_bit = amp[c[2:0]];
  endfunction
  task automatic chk_frame(input int n, input logic [1:0] last);
    int d;
    d = 0;
    chk("bit count", 24'(n), 24'(chain_u.bits_q.size()));
    for (int i = 0; i < n && i < chain_u.bits_q.size(); i++) begin
      chk("chain bit", {23'h0, exp_bit(cfg[i][4:0], d)}, {23'h0, chain_u.bits_q[i]});
      chk("driver position", 24'(d), {22'h0, chain_u.pos_q[i]});
      if (cfg[i][5] && d != int'(last)) d++;
    end
    chk("position at end", 24'h0, {22'h0, drv_pos});
    chk("select at end", 24'h1, {23'h0, sel_n});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    host_write(7'h00, 24'hFFFFF2);
    host_check(7'h00, 24'h000002, "last index");
    host_check(7'h01, 24'h000000, "status idle");
    host_write(7'h05, 24'hFFFFFF);
    host_check(7'h05, 24'h000000, "unmapped register");
  endtask
  task automatic t_ram();
    for (int a = 0; a < 32; a++) begin
      host_write(7'h60 + 7'(a), {12'hFFF, 6'(2 * a + 1) ^ 6'h2A, 6'(2 * a) ^ 6'h2A});
    end
    for (int i = 0; i < 16; i++) begin
      cfg[i]      = {i == 15, 5'(i)};
      cfg[16 + i] = {i == 15, 5'(16 + i)};
    end
    cfg[32] = 6'h12;
    cfg[33] = 6'h13;
    cfg[34] = 6'h2F;
    cfg[35] = 6'h00;
    for (int a = 0; a < 18; a++) begin
      host_write(7'h40 + 7'(a), {12'hABC, cfg[2 * a + 1], cfg[2 * a]});
    end
    host_check(7'h4F, {12'h0, cfg[31], cfg[30]}, "config cells");
    host_check(7'h61, {12'h0, 6'h29, 6'h28}, "wave cells");
  endtask
  task automatic t_frame();
    int n;
    e_pos = mpos;
    e_dir = dir_v;
    e_step = step_v;
    e_fda = fda_v;
    e_fdb = fdb_v;
    chain_u.bits_q.delete();
    chain_u.pos_q.delete();
    @(posedge clock_in);
    start <= 1'b1;
    @(posedge clock_in);
    start <= 1'b0;
    n = 0;
    while (sel_n !== 1'b0 && n < 20) begin
      @(posedge clock_in);
      n++;
    end
    if (sel_n !== 1'b0) begin
      error_cnt++;
      summarize();
    end
    host_check(7'h01, 24'h000004, "status busy");
    // inputs move during the frame and must not show
    @(posedge clock_in);
    mpos   <= {8'h77, 8'h21, 8'hB6};
    dir_v  <= ~dir_v;
    step_v <= ~step_v;
    fda_v  <= ~fda_v;
    fdb_v  <= ~fdb_v;
    start  <= 1'b1;
    @(posedge clock_in);
    start  <= 1'b0;
    wait_idle();
    #10;
    chk_frame(35, 2'h2);
    repeat (12) @(posedge clock_in);
    #10;
    chk("busy after ignored start", 24'h0, {23'h0, busy});
  endtask
  task automatic t_reg_start();
    e_pos = mpos;
    e_dir = dir_v;
    e_step = step_v;
    e_fda = fda_v;
    e_fdb = fdb_v;
    chain_u.bits_q.delete();
    chain_u.pos_q.delete();
    host_write(7'h00, 24'h000004);
    repeat (3) @(posedge clock_in);
    wait_idle();
    #10;
    chk_frame(16, 2'h0);
    host_check(7'h00, 24'h000000, "control after start");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clock_in   = 1'b0;
    resetn_in  = 1'b0;
    host_addr  = 7'h00;
    host_wdata = 24'h000000;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    start      = 1'b0;
    mpos       = {8'hC3, 8'h4A, 8'h05};
    dir_v      = 3'h2;
    step_v     = 3'h5;
    fda_v      = 3'h3;
    fdb_v      = 3'h6;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_regs();
    t_ram();
    t_frame();
    t_reg_start();
    summarize();
  end
endmodule
